// File: rtl/agf_cfg.svh
/*
 * Constants for the address-generator alternate-set and fault block:
 * mode bit positions, vector levels, reset values, latency counts.
 * Assumes inclusion by bare name from rtl/ files.
 */
`ifndef AGF_CFG_SVH
`define AGF_CFG_SVH

// ----------------------------------------
// mode bit positions in the 9-bit mode word
// ----------------------------------------
`define AGF_MB_ALT_G1LO 0
`define AGF_MB_ALT_G1HI 1
`define AGF_MB_ALT_G2LO 2
`define AGF_MB_ALT_G2HI 3
`define AGF_MB_CBUF 4
`define AGF_MB_BR1 5
`define AGF_MB_BR2 6
`define AGF_MB_BC1 7
`define AGF_MB_BC2 8
`define AGF_MODE_W 9
`define AGF_MODE_RST 9'h000

// ----------------------------------------
// vector levels
// ----------------------------------------
`define AGF_LVL_CB7 5'h05
`define AGF_LVL_CB15 5'h15
`define AGF_LVL_IIC 5'h06
`define AGF_LVL_ILAD 5'h08

// ----------------------------------------
// timing
// ----------------------------------------
`define AGF_ALT_LAT 1

`endif

// File: rtl/agf_pkg.sv
/*
 * Types shared by the address-generator fault block.
 * Assumes agf_cfg.svh is on the include path.
 */
`default_nettype none
package agf_pkg;

   typedef enum logic [1:0] {
      AGF_SP_LONG = 2'b00,
      AGF_SP_NORM = 2'b01,
      AGF_SP_SHORT = 2'b10,
      AGF_SP_BYTE = 2'b11
   } agf_space_t;

   typedef enum logic [1:0] {
      AGF_SZ_BYTE = 2'b00,
      AGF_SZ_SHORT = 2'b01,
      AGF_SZ_NORM = 2'b10,
      AGF_SZ_LONG = 2'b11
   } agf_size_t;

   typedef enum logic [1:0] {
      AGF_OP_MEM = 2'b00,
      AGF_OP_MOD = 2'b01,
      AGF_OP_B2W = 2'b10,
      AGF_OP_W2B = 2'b11
   } agf_op_t;

   // one address-generator request from the sequencer
   typedef struct packed {
      logic valid;
      agf_op_t op;
      agf_size_t size;
      agf_space_t space;
      logic b2wEquiv;
      logic exclusive;
      logic external;
      logic mmrHit;
      logic [31:0] addr;
      logic [3:0] index;
      logic [31:0] newIndex;
      logic multiWord;
   } agf_req_t;

   // index-register update for wrap detection
   typedef struct packed {
      logic valid;
      logic circ;
      logic [3:0] index;
      logic [31:0] oldVal;
      logic [31:0] newVal;
      logic [31:0] base;
      logic [31:0] length;
      logic wrapped;
   } agf_iupd_t;

endpackage
`default_nettype wire

// File: rtl/agf_align_chk.sv
/*
 * Alignment checker: decides the legal boundary of an access and
 * produces the force-aligned address.
 * Assumes byte addressing and combinational use by the main block.
 */
`include "agf_cfg.svh"
`default_nettype none
module agf_align_chk
   import agf_pkg::*;
(
   input wire agf_size_t size,
   input wire logic paired,
   input wire logic exclusive,
   input wire logic external,
   input wire logic wideMode,
   input wire logic [31:0] addr,
   output logic misaligned,
   output logic rowSpan,
   output logic [31:0] alignedAddr
);

   logic [2:0] lowMask;

   // ----------------------------------------
   // required boundary per size and mode
   // ----------------------------------------
   always_comb begin
      lowMask = 3'h0;
      if (exclusive) begin
         case (size)  // [RULE_17]
            AGF_SZ_BYTE: lowMask = paired ? 3'h1 : 3'h0;
            AGF_SZ_SHORT: lowMask = paired ? 3'h3 : 3'h1;
            AGF_SZ_NORM: lowMask = paired ? 3'h7 : 3'h3;
            default: lowMask = 3'h0;
         endcase
      end else begin
         case (size)  // [RULE_16]
            AGF_SZ_BYTE: lowMask = 3'h0;
            AGF_SZ_SHORT: lowMask = (external && wideMode) ? 3'h1 : 3'h0;
            AGF_SZ_NORM: lowMask = (paired || (external && wideMode)) ? 3'h3 : 3'h0;
            default: lowMask = 3'h7;
         endcase
      end
   end

   assign misaligned = |(addr[2:0] & lowMask);
   assign rowSpan = (size == AGF_SZ_LONG) && (addr[2:0] != 3'h0);
   // round down to the nearest legal boundary
   assign alignedAddr = {addr[31:3], addr[2:0] & ~lowMask};  // [RULE_15]

endmodule
`default_nettype wire

// File: rtl/agf_fault_unit.sv
/*
 * Address-generator alternate-set control, mode masking on interrupt
 * entry, circular-buffer wrap events and access fault detection.
 * Assumes the sequencer presents requests on clk_sys and the register
 * banks use the select outputs; no bus, all controls are ports.
 */
`include "agf_cfg.svh"
`default_nettype none
// Function
// RULE_01 - alternate bank untouched while not selected
// RULE_02 - new bank selection active one cycle later
// RULE_03 - four select bits, one per half
// RULE_04 - masked mode bits forced on interrupt entry
// RULE_05 - mask covers selects, circ, bitrev, broadcast
// RULE_06 - index 7 wrap level 5, 15 level 21
// RULE_07 - zero length: fire every change past base
// RULE_08 - multiword access completes before wrap acts
// RULE_09 - software picks base/length avoiding wraps
// RULE_10 - illegal address space events at level 8
// RULE_11 - normal-word access never address-faults
// RULE_12 - normal modify in normal space acts byte
// RULE_13 - mapped-register access raises level 6
// RULE_14 - row-spanning 64-bit access sets sticky
// RULE_15 - misaligned access faults, force-aligned down
// RULE_16 - plain alignment by size and mode
// RULE_17 - exclusive alignment by size and mode
// RULE_18 - paired conditional explicit/implicit gating
// RULE_19 - wrap sets sticky overflow flag
// RULE_20 - circ off: plain post-modify, base loads index
module agf_fault_unit
   import agf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   // mode register write from the sequencer
   input wire logic modeWrEn,
   input wire logic [`AGF_MODE_W-1:0] modeWrData,
   input wire logic [`AGF_MODE_W-1:0] isrModeMask,
   input wire logic [`AGF_MODE_W-1:0] isrModeValue,
   input wire logic isrEntry,
   input wire logic paired_element_enable,
   input wire logic illegal_mmr_access_enable,
   input wire logic unaligned_access_monitor_enable,
   input wire logic extended_width_mode,
   input wire logic iicUnmasked,
   input wire logic condExplicit,
   input wire logic condImplicit,
   input wire logic stickyClear,
   input wire agf_req_t req,
   input wire agf_iupd_t iupd,
   output logic [`AGF_MODE_W-1:0] modeOut,
   output logic [3:0] altSelActive,
   output logic [3:0] altWriteEn,
   output logic [3:0] priWriteEn,
   output logic circActive,
   output logic baseLoadsIndex,
   output logic [31:0] accessAddr,
   output logic explicitXfer,
   output logic implicitXfer,
   output logic wrap_irq_index7,
   output logic wrap_irq_index15,
   output logic illegal_input_condition_irq,
   output logic illegal_address_space_irq,
   output logic [4:0] irqLevel,
   output logic [3:0] sticky_status_reg
);

   logic [`AGF_MODE_W-1:0] mode_ff, nxt_mode;
   logic [3:0] altSel_ff, nxt_altSel;
   logic [3:0] sticky_ff, nxt_sticky;
   logic cb7_ff, nxt_cb7, cb15_ff, nxt_cb15;
   logic iic_ff, nxt_iic, ilad_ff, nxt_ilad;
   logic [4:0] lvl_ff, nxt_lvl;
   logic [31:0] addr_ff, nxt_addr;
   logic expl_ff, nxt_expl, impl_ff, nxt_impl;
   logic pendCb7_ff, nxt_pendCb7, pendCb15_ff, nxt_pendCb15;
   logic misaligned, rowSpan;
   logic [31:0] alignedAddr;
   logic ilad, mmrFault, alnFault, wrapEvt, crossBase;
   logic memReq;

   // ----------------------------------------
   // alignment
   // ----------------------------------------
   agf_align_chk u_align (
      .size(req.size),
      .paired(paired_element_enable),
      .exclusive(req.exclusive),
      .external(req.external),
      .wideMode(extended_width_mode),
      .addr(req.addr),
      .misaligned(misaligned),
      .rowSpan(rowSpan),
      .alignedAddr(alignedAddr)
   );

   // ----------------------------------------
   // mode register
   // ----------------------------------------
   always_comb begin
      nxt_mode = mode_ff;
      if (modeWrEn) begin
         nxt_mode = modeWrData;
      end
      if (isrEntry) begin
         // only masked bits are forced, the rest keep their value or take a same-cycle mode write
         nxt_mode = (nxt_mode & ~isrModeMask) | (isrModeValue & isrModeMask);  // [RULE_04] [RULE_05]
      end
      // the selects take effect from the stored mode, hence one cycle late
      nxt_altSel = mode_ff[`AGF_MB_ALT_G2HI:`AGF_MB_ALT_G1LO];  // [RULE_02] [RULE_03]
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_ff <= `AGF_MODE_RST;
         altSel_ff <= 4'h0;
      end else begin
         mode_ff <= nxt_mode;
         altSel_ff <= nxt_altSel;
      end
   end

   assign modeOut = mode_ff;
   assign altSelActive = altSel_ff;
   // a half's write strobe reaches only the bank that is selected
   assign altWriteEn = altSel_ff;  // [RULE_01]
   assign priWriteEn = ~altSel_ff;  // [RULE_01]
   assign circActive = mode_ff[`AGF_MB_CBUF];  // [RULE_20]
   assign baseLoadsIndex = 1'b1;  // [RULE_20]

   // ----------------------------------------
   // illegal address space decode
   // ----------------------------------------
   always_comb begin
      ilad = 1'b0;
      case (req.op)
         AGF_OP_MEM: begin
            case (req.size)
               AGF_SZ_BYTE, AGF_SZ_SHORT: ilad = (req.space != AGF_SP_BYTE);  // [RULE_10]
               AGF_SZ_LONG: ilad = (req.space == AGF_SP_SHORT);  // [RULE_10]
               default: ilad = 1'b0;  // [RULE_11]
            endcase
         end
         AGF_OP_MOD: begin
            case (req.size)
               AGF_SZ_SHORT: ilad = (req.space != AGF_SP_BYTE);  // [RULE_10]
               // normal modify in normal space behaves as a byte modify
               AGF_SZ_NORM: ilad = (req.space == AGF_SP_LONG) ||
                                   (req.space == AGF_SP_SHORT);  // [RULE_10] [RULE_12]
               default: ilad = 1'b0;
            endcase
         end
         AGF_OP_B2W: ilad = (req.space == AGF_SP_LONG) || (req.space == AGF_SP_SHORT) ||
                            ((req.space == AGF_SP_BYTE) && !req.b2wEquiv);  // [RULE_10]
         AGF_OP_W2B: ilad = (req.space == AGF_SP_LONG) ||
                            (req.space == AGF_SP_SHORT);  // [RULE_10]
         default: ilad = 1'b0;
      endcase
   end

   assign memReq = req.valid && (req.op == AGF_OP_MEM);
   assign mmrFault = memReq && illegal_mmr_access_enable && req.mmrHit;  // [RULE_13]
   assign alnFault = memReq && unaligned_access_monitor_enable && misaligned;  // [RULE_15]

   // ----------------------------------------
   // circular wrap detection on index 7 and 15
   // ----------------------------------------
   // zero length: every change after the index has passed its base
   assign crossBase = (iupd.oldVal < iupd.base) != (iupd.newVal < iupd.base) ||
                      (iupd.newVal >= iupd.base);
   always_comb begin
      wrapEvt = 1'b0;
      if (iupd.valid && iupd.circ && mode_ff[`AGF_MB_CBUF]) begin
         if (iupd.length == 32'h0) begin
            wrapEvt = (iupd.newVal != iupd.oldVal) && crossBase;  // [RULE_07]
         end else begin
            wrapEvt = iupd.wrapped;  // [RULE_19]
         end
      end
   end

   // ----------------------------------------
   // events, sticky status, transfer outputs
   // ----------------------------------------
   always_comb begin
      nxt_pendCb7 = pendCb7_ff;
      nxt_pendCb15 = pendCb15_ff;
      nxt_cb7 = 1'b0;
      nxt_cb15 = 1'b0;
      nxt_sticky = sticky_ff;
      if (stickyClear) begin
         nxt_sticky = 4'h0;
      end
      if (wrapEvt && (iupd.index == 4'h7)) begin
         nxt_pendCb7 = 1'b1;
         nxt_sticky[0] = 1'b1;  // [RULE_19]
      end
      if (wrapEvt && (iupd.index == 4'hF)) begin
         nxt_pendCb15 = 1'b1;
         nxt_sticky[1] = 1'b1;  // [RULE_19]
      end
      // multiword accesses finish before the wrap is acted on
      if (!(req.valid && req.multiWord)) begin  // [RULE_08]
         nxt_cb7 = nxt_pendCb7;  // [RULE_06]
         nxt_cb15 = nxt_pendCb15;  // [RULE_06]
         nxt_pendCb7 = 1'b0;
         nxt_pendCb15 = 1'b0;
      end
      if (memReq && unaligned_access_monitor_enable && (req.size == AGF_SZ_LONG) && rowSpan) begin
         nxt_sticky[2] = 1'b1;  // [RULE_14]
      end
      if (mmrFault) begin
         nxt_sticky[3] = 1'b1;
      end
      nxt_ilad = req.valid && ilad;  // [RULE_10]
      // a misaligned access only interrupts when the level is unmasked; a non-exclusive row-span interrupts as misaligned
      nxt_iic = mmrFault || (alnFault && iicUnmasked);  // [RULE_13] [RULE_14] [RULE_15]
      if (nxt_ilad) begin
         nxt_lvl = `AGF_LVL_ILAD;
      end else if (nxt_iic) begin
         nxt_lvl = `AGF_LVL_IIC;
      end else if (nxt_cb7) begin
         nxt_lvl = `AGF_LVL_CB7;
      end else if (nxt_cb15) begin
         nxt_lvl = `AGF_LVL_CB15;
      end else begin
         nxt_lvl = 5'h00;
      end
      nxt_addr = addr_ff;
      nxt_expl = 1'b0;
      nxt_impl = 1'b0;
      if (memReq) begin
         nxt_addr = unaligned_access_monitor_enable ? alignedAddr : req.addr;  // [RULE_15]
         nxt_expl = paired_element_enable ? condExplicit : 1'b1;  // [RULE_18]
         nxt_impl = paired_element_enable && condImplicit;  // [RULE_18]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sticky_ff <= 4'h0;
         cb7_ff <= 1'b0;
         cb15_ff <= 1'b0;
         pendCb7_ff <= 1'b0;
         pendCb15_ff <= 1'b0;
         iic_ff <= 1'b0;
         ilad_ff <= 1'b0;
         lvl_ff <= 5'h00;
         addr_ff <= 32'h0000_0000;
         expl_ff <= 1'b0;
         impl_ff <= 1'b0;
      end else begin
         sticky_ff <= nxt_sticky;
         cb7_ff <= nxt_cb7;
         cb15_ff <= nxt_cb15;
         pendCb7_ff <= nxt_pendCb7;
         pendCb15_ff <= nxt_pendCb15;
         iic_ff <= nxt_iic;
         ilad_ff <= nxt_ilad;
         lvl_ff <= nxt_lvl;
         addr_ff <= nxt_addr;
         expl_ff <= nxt_expl;
         impl_ff <= nxt_impl;
      end
   end

   assign wrap_irq_index7 = cb7_ff;
   assign wrap_irq_index15 = cb15_ff;
   assign illegal_input_condition_irq = iic_ff;
   assign illegal_address_space_irq = ilad_ff;
   assign irqLevel = lvl_ff;
   assign accessAddr = addr_ff;
   assign explicitXfer = expl_ff;
   assign implicitXfer = impl_ff;
   assign sticky_status_reg = sticky_ff;

endmodule
`default_nettype wire

// File: test/agf_seq_model.sv
/* Sequencer and index-update model: packs bench commands into request structs.
   Assumes inputs change at the falling clock edge. */
`default_nettype none
module agf_seq_model
   import agf_pkg::*;
(
   input wire logic go,
   input wire logic [5:0] cmd,
   input wire logic [31:0] addr,
   input wire logic mmr,
   input wire logic multi,
   input wire logic iuGo,
   input wire logic [3:0] iuIdx,
   input wire logic [31:0] iuLen,
   input wire logic iuWrap,
   output var agf_req_t req,
   output var agf_iupd_t iupd
);
   always_comb begin
      req = '0;
      iupd = '0;
      req.valid = go;
      req.op = agf_op_t'(cmd[5:4]);
      req.size = agf_size_t'(cmd[3:2]);
      req.space = agf_space_t'(cmd[1:0]);
      req.b2wEquiv = 1'b1;
      req.mmrHit = mmr;
      req.multiWord = go && multi;
      // idle bus shows the inverse, never a stale address
      req.addr = go ? addr : ~addr;
      iupd.valid = iuGo;
      iupd.circ = 1'b1;
      iupd.index = iuIdx;
      // base inside the walked range, so a zero-length update fires a wrap
      iupd.base = 32'h0000_1000;
      iupd.oldVal = 32'h0000_0FFC;
      iupd.newVal = 32'h0000_1004;
      iupd.length = iuLen;
      iupd.wrapped = iuWrap;
   end
endmodule
`default_nettype wire

// File: test/agf_fault_unit_asserts.sv
/* Port assertions for the fault block.
   Assumes one clock and synchronous srst. */
`include "agf_cfg.svh"
`default_nettype none
module agf_fault_asserts
   import agf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic modeWrEn,
   input wire logic [`AGF_MODE_W-1:0] modeWrData,
   input wire logic isrEntry,
   input wire logic illegal_mmr_access_enable,
   input wire logic unaligned_access_monitor_enable,
   input wire agf_req_t req,
   input wire agf_iupd_t iupd,
   input wire logic [`AGF_MODE_W-1:0] modeOut,
   input wire logic [3:0] altSelActive,
   input wire logic [3:0] altWriteEn,
   input wire logic [3:0] priWriteEn,
   input wire logic [31:0] accessAddr,
   input wire logic wrap_irq_index7,
   input wire logic illegal_input_condition_irq,
   input wire logic illegal_address_space_irq,
   input wire logic [4:0] irqLevel,
   input wire logic [3:0] sticky_status_reg
);
   logic [3:0] altReq;
   assign altReq = modeOut[3:0];
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_mode_write: assert property (
      modeWrEn && !isrEntry |=> modeOut == $past(modeWrData))
      else $error("mode word not loaded");
   a_alt_latency: assert property (
      !$past(srst) |-> altSelActive == $past(altReq))
      else $error("bank select latency wrong");
   a_alt_guard: assert property (
      altWriteEn == altSelActive && priWriteEn == ~altSelActive)
      else $error("unselected bank writable");
   a_wrap_seven: assert property (
      iupd.valid && iupd.index == 4'h7 && iupd.circ && iupd.wrapped
      && iupd.length != 32'h0 && modeOut[`AGF_MB_CBUF] && !(req.valid && req.multiWord)
      |=> wrap_irq_index7)
      else $error("index 7 wrap missed");
   a_wrap_sticky: assert property (
      wrap_irq_index7 |-> sticky_status_reg[0])
      else $error("wrap sticky not set");
   a_ilad_level: assert property (
      illegal_address_space_irq |-> irqLevel == `AGF_LVL_ILAD)
      else $error("address fault level wrong");
   a_mmr_fault: assert property (
      req.valid && req.op == AGF_OP_MEM && req.mmrHit && illegal_mmr_access_enable
      |=> illegal_input_condition_irq && sticky_status_reg[3])
      else $error("mapped register access missed");
   a_force_align: assert property (
      req.valid && req.op == AGF_OP_MEM && req.size == AGF_SZ_LONG
      && unaligned_access_monitor_enable |=> accessAddr[2:0] == 3'h0)
      else $error("long access not aligned");
endmodule
bind agf_fault_unit agf_fault_asserts chk_u (
   .clk_sys(clk_sys), .srst(srst), .modeWrEn(modeWrEn), .modeWrData(modeWrData),
   .isrEntry(isrEntry), .illegal_mmr_access_enable(illegal_mmr_access_enable),
   .unaligned_access_monitor_enable(unaligned_access_monitor_enable),
   .req(req), .iupd(iupd), .modeOut(modeOut), .altSelActive(altSelActive),
   .altWriteEn(altWriteEn), .priWriteEn(priWriteEn), .accessAddr(accessAddr),
   .wrap_irq_index7(wrap_irq_index7),
   .illegal_input_condition_irq(illegal_input_condition_irq),
   .illegal_address_space_irq(illegal_address_space_irq),
   .irqLevel(irqLevel), .sticky_status_reg(sticky_status_reg)
);
`default_nettype wire

// File: test/address_gen_alt_regs_and_faults_tb_top.sv
/* Testbench: mode, request and index-update sequences with expected events.
   Assumes rtl/ on the include path. */
`include "agf_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errorCnt++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module address_gen_alt_regs_and_faults_tb_top
   import agf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, srst = 1'b1, wrEn = 1'b0, isr = 1'b0, pe = 1'b0, mmrEn = 1'b0;
   logic mon = 1'b0, wide = 1'b0, iicUn = 1'b0, cExp = 1'b0, cImp = 1'b0, stClr = 1'b0;
   logic go = 1'b0, mmr = 1'b0, iuGo = 1'b0, iuWrap = 1'b0, multi = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic [3:0] iuIdx = 4'h0;
   logic [31:0] addr = 32'h0, iuLen = 32'h0;
   logic [8:0] wrData = 9'h000, mask = 9'h000, val = 9'h000, expMode, modeOut;
   agf_req_t req;
   agf_iupd_t iupd;
   logic [3:0] altSel, altWr, priWr, sticky;
   logic [31:0] accAddr;
   logic circAct, bLoad, expX, impX, w7, w15, iic, ilad;
   logic [4:0] lvl;
   int errorCnt = 0, checks = 0, cyc = 0;
   agf_seq_model seq_u (.go(go), .cmd(cmd), .addr(addr), .mmr(mmr), .multi(multi), .iuGo(iuGo),
      .iuIdx(iuIdx), .iuLen(iuLen), .iuWrap(iuWrap), .req(req), .iupd(iupd));
   agf_fault_unit dut_u (.clk_sys(clk_sys), .srst(srst), .modeWrEn(wrEn),
      .modeWrData(wrData), .isrModeMask(mask), .isrModeValue(val), .isrEntry(isr),
      .paired_element_enable(pe), .illegal_mmr_access_enable(mmrEn),
      .unaligned_access_monitor_enable(mon), .extended_width_mode(wide),
      .iicUnmasked(iicUn), .condExplicit(cExp), .condImplicit(cImp),
      .stickyClear(stClr), .req(req), .iupd(iupd), .modeOut(modeOut),
      .altSelActive(altSel), .altWriteEn(altWr), .priWriteEn(priWr),
      .circActive(circAct), .baseLoadsIndex(bLoad), .accessAddr(accAddr),
      .explicitXfer(expX), .implicitXfer(impX), .wrap_irq_index7(w7),
      .wrap_irq_index15(w15), .illegal_input_condition_irq(iic),
      .illegal_address_space_irq(ilad), .irqLevel(lvl), .sticky_status_reg(sticky));
   always #25 clk_sys = ~clk_sys;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         errorCnt++;
         end_sim();
      end
   end
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask
   task automatic mw(input logic [8:0] d);
      wrData = d;
      pulse(wrEn);
   endtask
   task automatic send(input logic [5:0] c, input logic [31:0] a, input logic m);
      cmd = c;
      addr = a;
      mmr = m;
      pulse(go); // idle cycle ahead keeps requests off a fresh mode write
   endtask
   task automatic upd(input logic [3:0] i, input logic [31:0] len, input logic wr);
      iuIdx = i;
      iuLen = len;
      iuWrap = wr;
      pulse(iuGo);
   endtask
   // cmd is {op, size, space}
   function automatic logic ilad_exp(input logic [5:0] c);
      logic [1:0] s = c[3:2];
      logic [1:0] p = c[1:0];
      case (c[5:4])
         2'h0: return (s < 2'h2 && p != 2'h3) || (s == 2'h3 && p == 2'h2);
         2'h1: return (s == 2'h1 && p != 2'h3) || (s == 2'h2 && !p[0]);
         default: return !p[0];
      endcase
   endfunction
   initial begin
      repeat (16) @(negedge clk_sys);
      srst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         mw(9'h001 << i);
         `CHK("modeOut", 9'h001 << i, modeOut);
         `CHK("altSel early", i ? 4'h1 << (i - 1) : 4'h0, altSel);
         @(negedge clk_sys);
         `CHK("altSel", 4'h1 << i, altSel);
         `CHK("altWr", 4'h1 << i, altWr);
         `CHK("priWr", ~(4'h1 << i), priWr);
      end
      $display("alt test done");
      mw(9'h0AA);
      expMode = 9'h0AA;
      for (int k = 0; k < 2; k++) begin
         mask = k ? 9'h0AA : 9'h155;
         val = 9'h0F3;
         expMode = (expMode & ~mask) | (val & mask);
         pulse(isr);
         `CHK("isr mode", expMode, modeOut);
      end
      $display("isr test done");
      mw(9'h000);
      for (int c = 0; c < 64; c++) begin
         send(c[5:0], 32'h0000_1000, 1'b0);
         `CHK("ilad", ilad_exp(c[5:0]), ilad);
         if (ilad_exp(c[5:0]))
            `CHK("lvl", `AGF_LVL_ILAD, lvl);
      end
      $display("space test done");
      mmrEn = 1'b1;
      send(6'h09, 32'h0000_2000, 1'b1);
      `CHK("iic mmr", 1'b1, iic);
      `CHK("lvl", `AGF_LVL_IIC, lvl);
      `CHK("sticky mmr", 1'b1, sticky[3]);
      mmrEn = 1'b0;
      send(6'h09, 32'h0000_2000, 1'b1);
      `CHK("iic off", 1'b0, iic);
      pulse(stClr);
      `CHK("sticky clr", 4'h0, sticky);
      $display("mmr test done");
      mw(9'h010);
      for (int k = 0; k < 4; k++) begin
         upd(k[0] ? 4'hF : 4'h7, k[1] ? 32'h0 : 32'h10, !k[1]);
         `CHK("w7", !k[0], w7);
         `CHK("w15", k[0], w15);
         `CHK("lvl", k[0] ? `AGF_LVL_CB15 : `AGF_LVL_CB7, lvl);
         `CHK("sticky wrap", 1'b1, sticky[k[0]]);
      end
      mw(9'h000);
      upd(4'h7, 32'h10, 1'b1);
      `CHK("w7 off", 1'b0, w7);
      `CHK("circ", 1'b0, circAct);
      `CHK("base load", 1'b1, bLoad);
      $display("wrap test done");
      mon = 1'b1;
      iicUn = 1'b1;
      send(6'h0D, 32'h0000_1005, 1'b0);
      `CHK("iic mis", 1'b1, iic);
      `CHK("addr", 32'h0000_1000, accAddr);
      `CHK("row span", 1'b1, sticky[2]);
      pe = 1'b1;
      cExp = 1'b1;
      send(6'h09, 32'h0000_1008, 1'b0);
      `CHK("iic ok", 1'b0, iic);
      `CHK("addr", 32'h0000_1008, accAddr);
      `CHK("xfer", 2'b10, {expX, impX});
      // wrap raised under a long access waits for the access to finish
      mw(9'h010);
      multi = 1'b1;
      fork
         send(6'h0F, 32'h0000_1000, 1'b0);
         upd(4'h7, 32'h10, 1'b1);
      join
      `CHK("w7 held", 1'b0, w7);
      @(negedge clk_sys);
      `CHK("w7 late", 1'b1, w7);
      $display("align test done");
      end_sim();
   end
endmodule
`default_nettype wire
